/* File: hw/sensor_fifo_frame_readout.sv */
// Frame FIFO of a pressure/temperature sensor with register readout,
// overflow policy, control frames and an interrupt pin.
// Assumes an Avalon-MM master on the same clock and measurement inputs
// that come from logic on that clock.
`timescale 1ns/1ps

// What this block does
// [R1] Data port address never advances; burst drains all
// [R2] Full when free space below nine bytes
// [R3] Streaming mode deletes oldest frames until fit
// [R4] Stop mode discards incoming frame while full
// [R5] Header: kind, parameter, two zero bits
// [R6] Kind codes: sensor, control (config error, config change)
// [R7] Enable bits select timestamp, measurement, empty
// [R8] Timestamp appended after data, captured live
// [R9] Temperature then pressure, disabled channel omitted
// [R10] Empty FIFO returns header 0x80 plus zero
// [R11] Config error stores control frame 0x44 0x01
// [R12] One change frame before first new frame
// [R13] Boundary stop resumes at next unread frame
// [R14] Mid-frame stop resends whole frame next time
// [R15] Overwritten partial frame skipped, oldest sent
// [R16] Partial timestamp never repeated, always live
// [R17] Final byte read consumes the frame
// [R18] Over-read: one timestamp, then empty frames
// [R19] Flush and soft reset commands empty FIFO
// [R20] Pin ORs watermark, full, data ready
// [R21] Reset: push-pull, active high pin
// [R22] Non-latched live; latched uses stored status
// [R23] Pin pulse at least one microsecond
// [R24] Storage of 512 bytes
// [R25] Fill count moves by whole frames only
// [R26] Full interrupt at 504 unread bytes
module sensor_fifo_frame_readout #(
  parameter int DEPTH = sensor_fifo_pkg::FIFO_BYTES,
  parameter int DRDY_CYCLES = sensor_fifo_pkg::DRDY_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic meas_valid,
  input wire sensor_fifo_pkg::meas_t meas,
  input wire logic cfg_err,
  input wire logic cfg_change,
  input wire logic [23:0] sensor_time,
  output logic int_pin,
  output logic int_pin_oe
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = $clog2(sensor_fifo_pkg::TINT_CYC + 1);
  localparam int DW = $clog2(DRDY_CYCLES + 1);

  // Length of a stored or generated frame from its header
  function automatic logic [3:0] frame_len(input logic [7:0] h);
    logic [3:0] n;
    n = sensor_fifo_pkg::LEN_ONE;
    if (h[7:6] == sensor_fifo_pkg::KIND_CTRL) begin
      n = sensor_fifo_pkg::LEN_CTRL;
    end else if (h[7:6] == sensor_fifo_pkg::KIND_SENSOR) begin
      if (h[sensor_fifo_pkg::BIT_TIME]) begin
        n = sensor_fifo_pkg::LEN_TIME; // [R7]
      end else if (!h[sensor_fifo_pkg::BIT_TEMP] &&
                   !h[sensor_fifo_pkg::BIT_PRESS]) begin
        n = sensor_fifo_pkg::LEN_EMPTY;
      end else begin
        n = sensor_fifo_pkg::LEN_ONE
          + (h[sensor_fifo_pkg::BIT_TEMP] ? sensor_fifo_pkg::LEN_CH : 4'h0)
          + (h[sensor_fifo_pkg::BIT_PRESS] ? sensor_fifo_pkg::LEN_CH : 4'h0);
      end
    end
    return n;
  endfunction : frame_len

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : lane_merge

  logic [7:0] mem [DEPTH]; // [R24]
  sensor_fifo_pkg::ctrl_t ctrl_q;
  logic [CW-1:0] wtm_q;
  logic [CW-1:0] count_q, count_d;
  logic [PW-1:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
  logic [3:0] rd_off_q, rd_off_d;
  logic ack_q;
  logic [31:0] rdata_q;
  sensor_fifo_pkg::rsel_t sel_q;
  logic [1:0] ts_off_q;
  logic ts_done_q;
  logic [2:0][7:0] ts_cap_q;
  logic emp_off_q;
  sensor_fifo_pkg::wstate_t wst_q;
  logic [8:0][7:0] wbuf_q;
  logic [3:0] wlen_q, widx_q;
  logic meas_pend_q, err_pend_q, chg_pend_q;
  sensor_fifo_pkg::meas_t meas_hold_q;
  logic fwm_st_q, full_st_q, drdy_st_q, drdy_pin_q;
  logic [DW-1:0] drdy_cnt_q;
  logic [SW-1:0] str_cnt_q;
  logic act_q;

  // Bus decode: every access waits one cycle, then completes
  wire req = read | write;
  wire accept = req & ~ack_q;
  wire done = req & ack_q;
  wire [7:0] byte_addr = {3'h0, address, 2'b00};
  wire do_wr = done & write;
  wire do_rd = done & read;
  wire wr_ctrl = do_wr & (byte_addr == sensor_fifo_pkg::OFS_CTRL);
  wire wr_cmd = do_wr & (byte_addr == sensor_fifo_pkg::OFS_CMD)
              & byteenable[0];
  wire wr_wtm = do_wr & (byte_addr == sensor_fifo_pkg::OFS_WTM);
  wire rd_data = do_rd & (byte_addr == sensor_fifo_pkg::OFS_DATA);
  wire rd_ist = do_rd & (byte_addr == sensor_fifo_pkg::OFS_INTST);
  wire soft_rst = wr_cmd & (writedata[7:0] == sensor_fifo_pkg::CMD_SOFTRST);
  wire flush = soft_rst
             | (wr_cmd & (writedata[7:0] == sensor_fifo_pkg::CMD_FLUSH));
  // Any completed access other than a data read closes the burst
  wire burst_end = done & ~rd_data;
  assign waitrequest = accept;
  assign readdata = rdata_q;

  // Enables, fill state and header of the oldest frame
  wire fifo_on = ctrl_q.fifo_en & (ctrl_q.temp_en | ctrl_q.press_en);
  wire [CW-1:0] free = CW'(DEPTH) - count_q;
  wire fifo_full = free < CW'(sensor_fifo_pkg::MAX_FRAME); // [R2]
  wire [7:0] old_hdr = mem[rd_ptr_q];
  wire [3:0] old_len = frame_len(old_hdr);
  wire [CW-1:0] full_lvl = CW'(sensor_fifo_pkg::FULL_LEVEL);
  wire full_cond = count_q >= full_lvl; // [R26]
  wire wtm_cond = (wtm_q != '0) & (count_q >= wtm_q);

  // Writer events; a deletion suppresses a pop of the same frame
  wire commit = (wst_q == sensor_fifo_pkg::W_WRITE) & (widx_q == wlen_q - 4'h1);
  wire del = (wst_q == sensor_fifo_pkg::W_SPACE) & ~ctrl_q.stop_on_full
           & (free < CW'(wlen_q)) & (count_q != '0); // [R3]
  wire fifo_sel = rd_data & (sel_q == sensor_fifo_pkg::SEL_FIFO) & ~del;
  wire pop = fifo_sel & (rd_off_q + 4'h1 >= old_len); // [R17]

  // Byte source for the data port: unfinished frame first, then FIFO
  sensor_fifo_pkg::rsel_t sel_now;
  assign sel_now =
    (ts_off_q != 2'h0) ? sensor_fifo_pkg::SEL_TIME :
    emp_off_q ? sensor_fifo_pkg::SEL_EMPTY :
    (rd_off_q != 4'h0 || count_q != '0) ? sensor_fifo_pkg::SEL_FIFO :
    (ctrl_q.time_en && !ts_done_q) ? sensor_fifo_pkg::SEL_TIME : // [R18]
    sensor_fifo_pkg::SEL_EMPTY;
  wire [7:0] fifo_byte = mem[rd_ptr_q + PW'(rd_off_q)];
  wire [7:0] ts_byte = (ts_off_q == 2'h0) ? sensor_fifo_pkg::HDR_TIME
                     : ts_cap_q[ts_off_q - 2'h1];
  wire [7:0] emp_byte = emp_off_q ? sensor_fifo_pkg::EMPTY_DATA
                      : sensor_fifo_pkg::HDR_EMPTY; // [R10]
  wire [7:0] data_byte =
    (sel_now == sensor_fifo_pkg::SEL_FIFO) ? fifo_byte :
    (sel_now == sensor_fifo_pkg::SEL_TIME) ? ts_byte : emp_byte;

  // Interrupt status as software sees it
  wire fwm_vis = ctrl_q.int_latch ? fwm_st_q : wtm_cond;
  wire full_vis = ctrl_q.int_latch ? full_st_q : full_cond;
  wire [2:0] ist = {drdy_st_q, full_vis, fwm_vis};

  // Read word, sampled at accept so it stands at the completing edge
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    case (byte_addr)
      sensor_fifo_pkg::OFS_CTRL: rd_word = 32'(ctrl_q);
      sensor_fifo_pkg::OFS_FILL: rd_word = 32'(count_q); // [R25]
      sensor_fifo_pkg::OFS_DATA: rd_word = 32'(data_byte); // [R1]
      sensor_fifo_pkg::OFS_WTM: rd_word = 32'(wtm_q);
      sensor_fifo_pkg::OFS_INTST: rd_word = 32'(ist);
      default: rd_word = 32'h0;
    endcase
  end

  // Bus handshake and read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      sel_q <= sensor_fifo_pkg::SEL_EMPTY;
    end else begin
      ack_q <= accept;
      if (accept) begin
        rdata_q <= rd_word;
        sel_q <= sel_now;
      end
    end
  end

  // Register words with the written byte lanes merged in
  wire [31:0] ctrl_wr = lane_merge(32'(ctrl_q), writedata, byteenable);
  wire [31:0] wtm_wr = lane_merge(32'(wtm_q), writedata, byteenable);

  // Control registers; soft reset restores the pin defaults
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= sensor_fifo_pkg::CTRL_RST; // [R21]
      wtm_q <= '0;
    end else if (soft_rst) begin
      ctrl_q <= sensor_fifo_pkg::CTRL_RST; // [R21]
      wtm_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_wr[$bits(ctrl_q)-1:0];
      if (wr_wtm) wtm_q <= wtm_wr[CW-1:0];
    end
  end

  // Pointers and committed fill count, in whole frames
  always_comb begin
    count_d = count_q;
    rd_ptr_d = rd_ptr_q;
    rd_off_d = rd_off_q;
    wr_ptr_d = wr_ptr_q;
    if (commit) begin
      count_d = count_d + CW'(wlen_q); // [R25]
      wr_ptr_d = wr_ptr_q + PW'(wlen_q);
    end
    if (del || pop) begin
      count_d = count_d - CW'(old_len); // [R13]
      rd_ptr_d = rd_ptr_q + PW'(old_len);
    end
    if (del || pop || burst_end) begin
      rd_off_d = 4'h0; // [R14] [R15]
    end else if (fifo_sel) begin
      rd_off_d = rd_off_q + 4'h1;
    end
    if (flush) begin
      count_d = '0; // [R19]
      rd_ptr_d = '0;
      rd_off_d = 4'h0;
      wr_ptr_d = '0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      rd_ptr_q <= '0;
      rd_off_q <= 4'h0;
      wr_ptr_q <= '0;
    end else begin
      count_q <= count_d;
      rd_ptr_q <= rd_ptr_d;
      rd_off_q <= rd_off_d;
      wr_ptr_q <= wr_ptr_d;
    end
  end

  // Timestamp and empty frames are generated, never stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ts_off_q <= 2'h0;
      ts_done_q <= 1'b0;
      ts_cap_q <= '0;
      emp_off_q <= 1'b0;
    end else if (burst_end || flush) begin
      ts_off_q <= 2'h0; // [R16]
      ts_done_q <= 1'b0;
      emp_off_q <= 1'b0;
    end else if (rd_data && sel_q == sensor_fifo_pkg::SEL_TIME) begin
      if (ts_off_q == 2'h0) ts_cap_q <= sensor_time; // [R8]
      ts_off_q <= (ts_off_q == sensor_fifo_pkg::TS_LAST) ? 2'h0
                                                         : ts_off_q + 2'h1;
      if (ts_off_q == sensor_fifo_pkg::TS_LAST) ts_done_q <= 1'b1; // [R18]
    end else if (rd_data && sel_q == sensor_fifo_pkg::SEL_EMPTY) begin
      emp_off_q <= ~emp_off_q; // [R18]
    end
  end

  // Measurement frame: temperature then pressure, low byte first
  wire t_on = ctrl_q.temp_en;
  wire p_on = ctrl_q.press_en;
  wire [7:0] meas_hdr = sensor_fifo_pkg::HDR_EMPTY
                      | (8'(t_on) << sensor_fifo_pkg::BIT_TEMP)
                      | (8'(p_on) << sensor_fifo_pkg::BIT_PRESS); // [R5] [R6]
  wire [55:0] mframe = (t_on && p_on) ?
                       {meas_hold_q.press, meas_hold_q.temp, meas_hdr} :
                       t_on ? {24'h0, meas_hold_q.temp, meas_hdr} :
                       {24'h0, meas_hold_q.press, meas_hdr}; // [R9]
  wire [3:0] mlen = frame_len(meas_hdr);
  wire take_err = (wst_q == sensor_fifo_pkg::W_IDLE) & err_pend_q;
  wire take_meas = (wst_q == sensor_fifo_pkg::W_IDLE) & ~err_pend_q
                 & meas_pend_q;
  // Setup fields whose change marks the stream
  wire ctrl_moved = wr_ctrl & (ctrl_wr[4:0] != 5'(ctrl_q));
  wire chg_evt = ctrl_q.normal_mode & fifo_on & (cfg_change | ctrl_moved);

  // Pending requests; a new event wins over the take in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meas_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
      chg_pend_q <= 1'b0;
      meas_hold_q <= '0;
    end else if (flush) begin
      meas_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
      chg_pend_q <= 1'b0;
    end else begin
      if (meas_valid && fifo_on) meas_hold_q <= meas;
      meas_pend_q <= (meas_valid & fifo_on) | (meas_pend_q & ~take_meas);
      err_pend_q <= (cfg_err & fifo_on) | (err_pend_q & ~take_err); // [R11]
      chg_pend_q <= chg_evt | (chg_pend_q & ~take_meas); // [R12]
    end
  end

  // Writer: build frame, make room or drop, copy bytes, then commit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wst_q <= sensor_fifo_pkg::W_IDLE;
      wbuf_q <= '0;
      wlen_q <= 4'h0;
      widx_q <= 4'h0;
    end else if (flush) begin
      wst_q <= sensor_fifo_pkg::W_IDLE;
    end else begin
      case (wst_q)
        sensor_fifo_pkg::W_IDLE: begin
          widx_q <= 4'h0;
          if (take_err) begin
            wbuf_q <= {56'h0, sensor_fifo_pkg::OP_CFG_ERR,
                       sensor_fifo_pkg::HDR_CFG_ERR}; // [R11]
            wlen_q <= sensor_fifo_pkg::LEN_CTRL;
            wst_q <= sensor_fifo_pkg::W_SPACE;
          end else if (take_meas) begin
            // Change marker and its frame share one commit
            wbuf_q <= chg_pend_q ? {mframe, sensor_fifo_pkg::OP_CFG_CHG,
                                    sensor_fifo_pkg::HDR_CFG_CHG}
                                 : {16'h0, mframe}; // [R12]
            wlen_q <= chg_pend_q ? mlen + sensor_fifo_pkg::LEN_CTRL : mlen;
            wst_q <= sensor_fifo_pkg::W_SPACE;
          end
        end
        sensor_fifo_pkg::W_SPACE: begin
          if (ctrl_q.stop_on_full && fifo_full) begin
            wst_q <= sensor_fifo_pkg::W_IDLE; // [R4]
          end else if (free >= CW'(wlen_q)) begin
            wst_q <= sensor_fifo_pkg::W_WRITE; // [R3]
          end
        end
        sensor_fifo_pkg::W_WRITE: begin
          widx_q <= widx_q + 4'h1;
          if (commit) wst_q <= sensor_fifo_pkg::W_IDLE;
        end
        default: wst_q <= sensor_fifo_pkg::W_IDLE;
      endcase
    end
  end

  // Storage writes land beyond the committed area, never seen early
  always_ff @(posedge clock) begin
    if (wst_q == sensor_fifo_pkg::W_WRITE) begin
      mem[wr_ptr_q + PW'(widx_q)] <= wbuf_q[widx_q];
    end
  end

  // Sticky statuses; a new condition wins over the status read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fwm_st_q <= 1'b0;
      full_st_q <= 1'b0;
      drdy_st_q <= 1'b0;
    end else begin
      fwm_st_q <= wtm_cond | (fwm_st_q & ~rd_ist);
      full_st_q <= full_cond | (full_st_q & ~rd_ist);
      drdy_st_q <= meas_valid | (drdy_st_q & ~rd_ist);
    end
  end

  // Non-latched data ready contribution self-clears after its timeout
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      drdy_pin_q <= 1'b0;
      drdy_cnt_q <= '0;
    end else if (meas_valid && ctrl_q.drdy_en && !ctrl_q.int_latch) begin
      drdy_pin_q <= 1'b1;
      drdy_cnt_q <= DW'(DRDY_CYCLES);
    end else if (rd_ist || drdy_cnt_q == DW'(1)) begin
      drdy_pin_q <= 1'b0; // [R22]
      drdy_cnt_q <= '0;
    end else if (drdy_cnt_q != '0) begin
      drdy_cnt_q <= drdy_cnt_q - DW'(1);
    end
  end

  // Pin source: live conditions or stored statuses, ORed
  wire live_src = (ctrl_q.wtm_en & wtm_cond) | (ctrl_q.full_en & full_cond)
                | drdy_pin_q; // [R20] [R22]
  wire held_src = (ctrl_q.wtm_en & fwm_st_q) | (ctrl_q.full_en & full_st_q)
                | (ctrl_q.drdy_en & drdy_st_q); // [R20] [R22]
  wire raw_int = ctrl_q.int_latch ? held_src : live_src;
  wire act_d = raw_int | (str_cnt_q != '0);
  // Open drain only pulls toward the inactive-free level
  wire pin_lvl = ctrl_q.int_level ? act_q : ~act_q;
  assign int_pin = ctrl_q.int_od ? 1'b0 : pin_lvl;
  assign int_pin_oe = ctrl_q.int_od ? ~pin_lvl : 1'b1;

  // Stretch each pulse so a short condition is still seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_q <= 1'b0;
      str_cnt_q <= '0;
    end else begin
      act_q <= act_d;
      if (raw_int && !act_q) begin
        str_cnt_q <= SW'(sensor_fifo_pkg::TINT_CYC - 1); // [R23]
      end else if (str_cnt_q != '0) begin
        str_cnt_q <= str_cnt_q - SW'(1);
      end
    end
  end

  a_fill_bound: assert property (@(posedge clock) disable iff (rst) // [R24]
    count_q <= CW'(DEPTH)) else $error("fill count above capacity");
  a_stop_drop: assert property (@(posedge clock) disable iff (rst) // [R4]
    (wst_q == sensor_fifo_pkg::W_SPACE && ctrl_q.stop_on_full && fifo_full
     && !flush) |=> wst_q == sensor_fifo_pkg::W_IDLE && count_q <= $past(count_q))
    else $error("frame stored while full in stop mode");
  a_stream_del: assert property (@(posedge clock) disable iff (rst) // [R3]
    (del && !flush) |=> count_q < $past(count_q))
    else $error("overflow did not delete oldest frame");
  a_hdr_zero: assert property (@(posedge clock) disable iff (rst) // [R5]
    (wst_q == sensor_fifo_pkg::W_WRITE && widx_q == 4'h0)
    |-> wbuf_q[0][1:0] == 2'b00) else $error("header low bits set");
  a_empty_seq: assert property (@(posedge clock) disable iff (rst) // [R10]
    (accept && read && byte_addr == sensor_fifo_pkg::OFS_DATA
     && sel_now == sensor_fifo_pkg::SEL_EMPTY && !emp_off_q)
    |=> rdata_q[7:0] == sensor_fifo_pkg::HDR_EMPTY)
    else $error("empty frame header wrong");
  a_partial_rew: assert property (@(posedge clock) disable iff (rst) // [R14]
    burst_end |=> rd_off_q == 4'h0 && ts_off_q == 2'h0)
    else $error("partial frame not rewound");
  a_ts_live: assert property (@(posedge clock) disable iff (rst) // [R8]
    (rd_data && sel_q == sensor_fifo_pkg::SEL_TIME && ts_off_q == 2'h0
     && !burst_end && !flush) |=> ts_cap_q == $past(sensor_time))
    else $error("timestamp not captured at frame start");
  a_flush_cmd: assert property (@(posedge clock) disable iff (rst) // [R19]
    flush |=> count_q == '0 && rd_off_q == 4'h0)
    else $error("flush left data behind");
  a_whole_frame: assert property (@(posedge clock) disable iff (rst) // [R25]
    !$stable(count_q) |-> $past(commit || del || pop || flush))
    else $error("fill count moved without a frame");
  // Length of the current pin pulse, saturating; only the width check reads it
  logic [SW-1:0] hi_run_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_run_q <= '0;
    end else begin
      hi_run_q <= !act_q ? '0 : (&hi_run_q) ? hi_run_q : hi_run_q + SW'(1);
    end
  end

  a_pulse_min: assert property (@(posedge clock) disable iff (rst) // [R23]
    $fell(act_q) |-> hi_run_q >= SW'(sensor_fifo_pkg::TINT_CYC))
    else $error("interrupt pulse too short");
  a_drdy_expire: assert property (@(posedge clock) disable iff (rst) // [R22]
    (drdy_cnt_q == DW'(1) && !meas_valid) |=> !drdy_pin_q)
    else $error("data ready pin did not self-clear");

endmodule : sensor_fifo_frame_readout

/* File: hw/sensor_fifo_pkg.sv */
// Constants, carriers and register map of the frame-based sensor FIFO.
// Assumes a 10 MHz system clock and a word-addressed 32-bit register bus.
package sensor_fifo_pkg;

  // Timing
  localparam int CLK_NS = 100;
  localparam int TINT_NS = 1000;
  localparam int TINT_CYC = (TINT_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRDY_US = 2500;
  localparam int DRDY_CYC = DRDY_US * 1000 / CLK_NS;

  // Storage sizing
  localparam int FIFO_BYTES = 512;
  localparam int MAX_FRAME = 9;
  localparam int FULL_LEVEL = 504;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_FILL = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_WTM = 8'h10;
  localparam logic [7:0] OFS_INTST = 8'h14;

  // Command codes
  localparam logic [7:0] CMD_FLUSH = 8'hb0;
  localparam logic [7:0] CMD_SOFTRST = 8'hb6;

  // Frame header fields
  localparam logic [1:0] KIND_SENSOR = 2'h2;
  localparam logic [1:0] KIND_CTRL = 2'h1;
  localparam int BIT_TIME = 5;
  localparam int BIT_TEMP = 4;
  localparam int BIT_PRESS = 2;
  localparam logic [7:0] HDR_EMPTY = 8'h80;
  localparam logic [7:0] HDR_TIME = 8'ha0;
  localparam logic [7:0] HDR_CFG_ERR = 8'h44;
  localparam logic [7:0] OP_CFG_ERR = 8'h01;
  localparam logic [7:0] HDR_CFG_CHG = 8'h48;
  localparam logic [7:0] OP_CFG_CHG = 8'h00;
  localparam logic [7:0] EMPTY_DATA = 8'h00;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_CTRL = 4'h2;
  localparam logic [3:0] LEN_EMPTY = 4'h2;
  localparam logic [3:0] LEN_TIME = 4'h4;
  localparam logic [3:0] LEN_CH = 4'h3;
  localparam logic [1:0] TS_LAST = 2'h3;

  // Interrupt status bit positions
  localparam int IST_WTM = 0;
  localparam int IST_FULL = 1;
  localparam int IST_DRDY = 2;

  typedef struct packed {
    logic [23:0] press;
    logic [23:0] temp;
  } meas_t;

  typedef struct packed {
    logic normal_mode;
    logic drdy_en;
    logic full_en;
    logic wtm_en;
    logic int_level;
    logic int_od;
    logic int_latch;
    logic press_en;
    logic temp_en;
    logic time_en;
    logic stop_on_full;
    logic fifo_en;
  } ctrl_t;

  // Push-pull, active high, everything else off
  localparam ctrl_t CTRL_RST = 12'h080;

  typedef enum {SEL_FIFO, SEL_TIME, SEL_EMPTY} rsel_t;
  typedef enum {W_IDLE, W_SPACE, W_WRITE} wstate_t;

endpackage : sensor_fifo_pkg

/* File: tb/host_bus.sv */
// Host bus master model for the frame FIFO register port.
// Assumes one clock shared with the device and Avalon-MM waitrequest.
`timescale 1ns/1ps
module host_bus (
  input wire logic clock,
  output logic [2:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  // Idle bus from time zero so reset never sees a request
  initial begin
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
  end
  // Request held until waitrequest is sampled low, then released
  task automatic bus_write(input logic [2:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 1'b0;
  endtask : bus_write
  // Read data is taken at the same edge that sees waitrequest low
  task automatic bus_read(input logic [2:0] a, output logic [31:0] v);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    v = readdata;
    read <= 1'b0;
  endtask : bus_read
endmodule : host_bus

/* File: tb/tb.sv */
// Self-checking bench for the frame FIFO readout block.
// Assumes the host bus model and the design package are compiled first.
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] address;
  logic read, write, waitrequest, int_pin, int_pin_oe;
  logic [31:0] writedata, readdata, d;
  logic [3:0] byteenable;
  logic meas_valid = 1'b0;
  logic cfg_err = 1'b0;
  logic cfg_change = 1'b0;
  logic [23:0] sensor_time = 24'h000000;
  sensor_fifo_pkg::meas_t meas = '0;
  sensor_fifo_pkg::meas_t mv;
  int error_cnt = 0, tests_run = 0, seed = 72, cyc = 0, i;

  sensor_fifo_frame_readout #(.DRDY_CYCLES(40)) sensor_fifo_frame_readout_inst (
    .clock, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .meas_valid, .meas, .cfg_err,
    .cfg_change, .sensor_time, .int_pin, .int_pin_oe);
  host_bus host_bus_inst (.clock, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest);

  // Clock, live timestamp and a hang limit far above the run length
  always #50 clock = ~clock;
  always @(posedge clock) begin
    sensor_time <= sensor_time + 24'h000001;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk(input string w, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", w, e, g);
    end
  endtask : chk

  // One register byte read and compared
  task automatic rb(input logic [2:0] a, input logic [7:0] e, input string w);
    host_bus_inst.bus_read(a, d);
    chk(w, {24'h0, e}, {24'h0, d[7:0]});
  endtask : rb

  // Poll the fill count; the writer needs a few cycles per frame
  task automatic fill_wait(input logic [31:0] n);
    for (i = 0; i < 20; i++) begin
      host_bus_inst.bus_read(3'h2, d);
      if (d === n) break;
    end
    chk("fill", n, d);
  endtask : fill_wait

  // Header then temperature and pressure bytes, low byte first
  task automatic frame(input logic t, p);
    rb(3'h3, {2'b10, 1'b0, t, 1'b0, p, 2'b00}, "header");
    for (int k = 0; k < 6; k++)
      if (k < 3 ? t : p)
        rb(3'h3, 8'(mv >> (8 * k)), "payload");
  endtask : frame

  // Measurement pulse with random data, or a configuration error pulse
  task automatic pulse(input logic err);
    @(posedge clock);
    mv = {16'($random(seed)), $random(seed)};
    meas <= mv;
    meas_valid <= !err;
    cfg_err <= err;
    @(posedge clock);
    meas_valid <= 1'b0;
    cfg_err <= 1'b0;
  endtask : pulse

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    chk("pin", {30'h0, int_pin_oe, int_pin}, 32'h2);
    host_bus_inst.bus_read(3'h0, d);
    chk("ctrl", 32'h80, d);
    rb(3'h7, 8'h00, "unmapped");
    rb(3'h3, 8'h80, "empty");
    rb(3'h3, 8'h00, "empty");
    $display("test reset and empty done");
    host_bus_inst.bus_write(3'h0, 32'h49d);
    pulse(1'b0);
    fill_wait(7);
    chk("pin", {31'h0, int_pin}, 32'h1);
    frame(1'b1, 1'b1);
    rb(3'h3, 8'ha0, "stamp");
    repeat (3) host_bus_inst.bus_read(3'h3, d);
    rb(3'h3, 8'h80, "empty");
    repeat (50) @(posedge clock);
    chk("pin", {31'h0, int_pin}, 32'h0);
    $display("test full frame done");
    host_bus_inst.bus_write(3'h0, 32'h89);
    pulse(1'b1);
    pulse(1'b0);
    fill_wait(6);
    rb(3'h3, 8'h44, "control");
    rb(3'h3, 8'h01, "control");
    host_bus_inst.bus_read(3'h3, d);
    host_bus_inst.bus_read(3'h3, d);
    fill_wait(4);
    frame(1'b1, 1'b0);
    fill_wait(0);
    $display("test partial read done");
    host_bus_inst.bus_write(3'h0, 32'h29b);
    repeat (80) begin
      pulse(1'b0);
      repeat (8) @(posedge clock);
    end
    fill_wait(504);
    chk("pin", {31'h0, int_pin}, 32'h1);
    host_bus_inst.bus_write(3'h0, 32'h299);
    // First frame still fits in eight free bytes; the second forces a delete
    repeat (2) begin
      pulse(1'b0);
      repeat (10) @(posedge clock);
      fill_wait(511);
    end
    $display("test overflow done");
    for (int j = 0; j < 2; j++) begin
      host_bus_inst.bus_write(3'h1, {24'h0, j ? sensor_fifo_pkg::CMD_SOFTRST
        : sensor_fifo_pkg::CMD_FLUSH});
      fill_wait(0);
      chk("pin", {31'h0, int_pin}, 32'h0);
      pulse(1'b0);
    end
    host_bus_inst.bus_read(3'h0, d);
    chk("ctrl", 32'h80, d);
    $display("test flush done");
    host_bus_inst.bus_write(3'h0, 32'h889);
    cfg_change <= 1'b1;
    @(posedge clock);
    cfg_change <= 1'b0;
    pulse(1'b0);
    fill_wait(6);
    rb(3'h5, 8'h04, "flags");
    rb(3'h5, 8'h00, "flags");
    rb(3'h3, 8'h48, "change");
    rb(3'h3, 8'h00, "change");
    frame(1'b1, 1'b0);
    fill_wait(0);
    $display("test config change done");
    final_report();
  end
endmodule : tb
